// ---- rtl/flash_status_regs.vh ----
// Constants for the flash status and configuration register bank.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef FLASH_STATUS_REGS_VH
`define FLASH_STATUS_REGS_VH

// ==========================================================
// APB register offsets (byte addresses)
`define OFS_PRIMARY_STATUS 8'h00
`define OFS_CONFIGURATION_ONE 8'h04
`define OFS_SUSPEND_STATUS 8'h08
`define OFS_IRQ_STATUS 8'h0c
`define OFS_IRQ_MASK 8'h10
`define OFS_PART_CTRL 8'h14

// ==========================================================
// Primary status field positions
`define PST_LOCK 7
`define PST_PROG_ERR 6
`define PST_ERASE_ERR 5
`define PST_BP_HI 4
`define PST_BP_LO 2
`define PST_WEL 1
`define PST_BUSY 0

// ==========================================================
// Configuration one field positions
`define CFG_LAT_HI 7
`define CFG_LAT_LO 6
`define CFG_ORIGIN 5
`define CFG_RSVD 4
`define CFG_VOLATILE_BP 3
`define CFG_PARAM_TOP 2
`define CFG_QUAD 1
`define CFG_FREEZE 0

// ==========================================================
// Suspend status field positions
`define SUS_ERASE 1
`define SUS_PROG 0

// ==========================================================
// Interrupt event positions
`define IRQ_PROG_ERR 0
`define IRQ_ERASE_ERR 1
`define IRQ_WRITE_LOCKED 2
`define IRQ_CMD_REFUSED 3
`define IRQ_OP_DONE 4
`define IRQ_WIDTH 5

// ==========================================================
// Reset values
`define RST_PRIMARY_STATUS 8'h00
`define RST_CONFIGURATION_ONE 8'h00
`define RST_SUSPEND_STATUS 8'h00
`define RST_BP_VOLATILE 3'h7
`define RST_IRQ_MASK 5'h00

// ==========================================================
// Link command codes
`define OP_WRITE_REGS 8'h01
`define OP_PROGRAM 8'h02
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_STATUS 8'h05
`define OP_WRITE_ENABLE 8'h06
`define OP_READ_SUSPEND 8'h07
`define OP_READ_CONFIG 8'h35
`define OP_ERASE 8'hd8
`define OP_SOFT_RESET 8'hf0

// ==========================================================
// Timing counts
`define REG_WRITE_CYCLES 16

// ==========================================================
// Dummy cycles per latency code (fast double-rate, double-rate quad)
`define FAST_DDR_LC0 4'h2
`define FAST_DDR_LC1 4'h4
`define FAST_DDR_LC2 4'h5
`define FAST_DDR_LC3 4'h0
`define QUAD_DDR_LC0 4'h6
`define QUAD_DDR_LC1 4'h7
`define QUAD_DDR_LC2 4'h8
`define QUAD_DDR_LC3 4'h0

`endif

// ---- rtl/latency_lut.v ----
// Latency code to read dummy cycle lookup, registered outputs.
// Assumes the code input is synchronous to clk.
`timescale 1ns/1ps
`include "flash_status_regs.vh"

module latency_lut #(
  parameter [3:0] FAST_LC0 = `FAST_DDR_LC0,
  parameter [3:0] FAST_LC1 = `FAST_DDR_LC1,
  parameter [3:0] FAST_LC2 = `FAST_DDR_LC2,
  parameter [3:0] FAST_LC3 = `FAST_DDR_LC3,
  parameter [3:0] QUAD_LC0 = `QUAD_DDR_LC0,
  parameter [3:0] QUAD_LC1 = `QUAD_DDR_LC1,
  parameter [3:0] QUAD_LC2 = `QUAD_DDR_LC2,
  parameter [3:0] QUAD_LC3 = `QUAD_DDR_LC3
) (
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Selected code
  input wire [1:0] i_code,
  // Dummy cycle counts
  output reg [3:0] o_fast_ddr,
  output reg [3:0] o_quad_ddr
);

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_fast_ddr <= FAST_LC0;
      o_quad_ddr <= QUAD_LC0;
    end else begin
      case (i_code)
        2'h0: begin
          o_fast_ddr <= FAST_LC0;
          o_quad_ddr <= QUAD_LC0;
        end
        2'h1: begin
          o_fast_ddr <= FAST_LC1;
          o_quad_ddr <= QUAD_LC1;
        end
        2'h2: begin
          o_fast_ddr <= FAST_LC2;
          o_quad_ddr <= QUAD_LC2;
        end
        default: begin
          o_fast_ddr <= FAST_LC3;
          o_quad_ddr <= QUAD_LC3;
        end
      endcase
    end
  end

endmodule

// ---- rtl/flash_status_config_regs.v ----
// Status and configuration register bank of a serial NOR flash.
// Assumes link pins are asynchronous to I_REF_CLK and SCK runs well
// below a quarter of it; engine status inputs share I_REF_CLK.
`timescale 1ns/1ps
`include "flash_status_regs.vh"

module flash_status_config_regs #(
  parameter REG_WRITE_CYCLES = `REG_WRITE_CYCLES
) (
  // Clock and reset
  input wire I_REF_CLK,
  input wire I_SRST,
  // APB slave
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output reg O_PREADY,
  output reg O_PSLVERR,
  // Serial link pins
  input wire I_SCK,
  input wire I_CS_N,
  input wire I_SI,
  input wire I_WP_N,
  output reg O_SO,
  output reg O_SO_OE,
  // Array engine status
  input wire I_OP_BUSY,
  input wire I_PROG_ERR,
  input wire I_ERASE_ERR,
  input wire I_ERASE_SUSP,
  input wire I_PROG_SUSP,
  // Array engine control
  output reg O_PGM_START,
  output reg O_ERS_START,
  output reg [2:0] O_BLOCK_PROTECT,
  output reg O_PROT_BOTTOM,
  output reg O_PARAM_TOP,
  output reg O_QUAD_EN,
  output reg O_OTP_LOCK,
  output wire [3:0] O_FAST_DDR_DUMMY,
  output wire [3:0] O_QUAD_DDR_DUMMY,
  // Interrupt
  output reg O_IRQ
);

  // ==========================================================
  // Pin synchronisers
  reg [1:0] sck_sync_q;
  reg [1:0] cs_sync_q;
  reg [1:0] si_sync_q;
  reg [1:0] wp_sync_q;
  reg sck_prev_q;
  reg cs_prev_q;

  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      sck_sync_q <= 2'h0;
      cs_sync_q <= 2'h3;
      si_sync_q <= 2'h0;
      wp_sync_q <= 2'h3;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_sync_q <= {sck_sync_q[0], I_SCK};
      cs_sync_q <= {cs_sync_q[0], I_CS_N};
      si_sync_q <= {si_sync_q[0], I_SI};
      wp_sync_q <= {wp_sync_q[0], I_WP_N};
      sck_prev_q <= sck_sync_q[1];
      cs_prev_q <= cs_sync_q[1];
    end
  end

  wire cs_n = cs_sync_q[1];
  wire sck_rise = sck_sync_q[1] & ~sck_prev_q & ~cs_n;
  wire sck_fall = ~sck_sync_q[1] & sck_prev_q & ~cs_n;
  wire frame_end = cs_n & ~cs_prev_q;
  wire wp_low = ~wp_sync_q[1];

  // ==========================================================
  // Register state
  reg status_write_lock_q;
  reg [2:0] block_protect_q;
  reg write_enable_latch_q;
  reg busy_flag_q;
  reg prog_err_q;
  reg erase_err_q;
  reg [1:0] latency_code_q;
  reg protection_origin_q;
  reg protection_volatility_q;
  reg parameter_placement_q;
  reg quad_io_q;
  reg freeze_q;
  reg erase_suspended_flag_q;
  reg program_suspended_flag_q;
  reg [7:0] reg_busy_cnt_q;
  reg [`IRQ_WIDTH-1:0] irq_status_q;
  reg [`IRQ_WIDTH-1:0] irq_mask_q;
  reg uniform_sectors_q;

  wire [7:0] primary_status = {status_write_lock_q, prog_err_q,
    erase_err_q, block_protect_q, write_enable_latch_q, busy_flag_q};
  // Reserved bits tied low
  wire [7:0] configuration_one = {latency_code_q, protection_origin_q,
    1'b0, protection_volatility_q, parameter_placement_q, quad_io_q,
    freeze_q};
  wire [7:0] suspend_status = {6'h00, erase_suspended_flag_q,
    program_suspended_flag_q};

  // Busy covers engine work and our own register write time
  wire busy_now = I_OP_BUSY | (reg_busy_cnt_q != 8'h00);

  // ==========================================================
  // Link shifter
  reg [2:0] bit_cnt_q;
  reg [1:0] byte_idx_q;
  reg [6:0] shift_q;
  reg [7:0] opcode_q;
  reg [7:0] stat_byte_q;
  reg [7:0] cfg_byte_q;
  reg read_active_q;
  reg [2:0] out_idx_q;

  wire [7:0] rx_byte = {shift_q, si_sync_q[1]};
  wire byte_done = sck_rise & (bit_cnt_q == 3'h7);
  wire is_read = (rx_byte == `OP_READ_STATUS) |
    (rx_byte == `OP_READ_SUSPEND) | (rx_byte == `OP_READ_CONFIG);

  reg [7:0] read_sel;
  always @* begin
    read_sel = primary_status;
    if (opcode_q == `OP_READ_CONFIG) begin
      read_sel = configuration_one;
    end else if (opcode_q == `OP_READ_SUSPEND) begin
      read_sel = suspend_status;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      bit_cnt_q <= 3'h0;
      byte_idx_q <= 2'h0;
      shift_q <= 7'h00;
      opcode_q <= 8'h00;
      stat_byte_q <= 8'h00;
      cfg_byte_q <= 8'h00;
      read_active_q <= 1'b0;
      out_idx_q <= 3'h7;
      O_SO <= 1'b0;
      O_SO_OE <= 1'b0;
    end else if (cs_n) begin
      // A frame cut mid-byte leaves no partial state behind
      bit_cnt_q <= 3'h0;
      byte_idx_q <= 2'h0;
      read_active_q <= 1'b0;
      out_idx_q <= 3'h7;
      O_SO_OE <= 1'b0;
    end else begin
      if (sck_rise) begin
        shift_q <= rx_byte[6:0];
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (byte_done) begin
        if (byte_idx_q != 2'h3) begin
          byte_idx_q <= byte_idx_q + 2'h1;
        end
        if (byte_idx_q == 2'h0) begin
          opcode_q <= rx_byte;
          read_active_q <= is_read;
        end
        if (byte_idx_q == 2'h1) begin
          stat_byte_q <= rx_byte;
        end
        if (byte_idx_q == 2'h2) begin
          cfg_byte_q <= rx_byte;
        end
      end
      // Output changes on falling edge, host samples 10 ns before the next fall
      if (sck_fall && read_active_q) begin
        O_SO <= read_sel[out_idx_q];
        O_SO_OE <= 1'b1;
        out_idx_q <= out_idx_q - 3'h1;
      end
    end
  end

  // ==========================================================
  // Command execution at frame end
  wire whole_bytes = (bit_cnt_q == 3'h0) & (byte_idx_q != 2'h0);
  wire cmd_end = frame_end & whole_bytes;
  wire needs_wel = (opcode_q == `OP_WRITE_REGS) |
    (opcode_q == `OP_PROGRAM) | (opcode_q == `OP_ERASE);
  wire is_ctl = needs_wel | (opcode_q == `OP_WRITE_ENABLE) |
    (opcode_q == `OP_WRITE_DISABLE) | (opcode_q == `OP_SOFT_RESET);
  wire refused = cmd_end & is_ctl &
    (busy_now | (needs_wel & ~write_enable_latch_q));
  wire go = cmd_end & ~busy_now;
  wire go_wel = go & write_enable_latch_q;
  wire wr_locked = status_write_lock_q & wp_low;
  wire wr_regs = go_wel & (opcode_q == `OP_WRITE_REGS) &
    (byte_idx_q >= 2'h2);
  wire wr_ok = wr_regs & ~wr_locked;
  wire wr_cfg = wr_ok & (byte_idx_q == 2'h3);

  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      status_write_lock_q <= 1'b0;
      block_protect_q <= 3'h0;
      write_enable_latch_q <= 1'b0;
      latency_code_q <= 2'h0;
      protection_origin_q <= 1'b0;
      protection_volatility_q <= 1'b0;
      parameter_placement_q <= 1'b0;
      quad_io_q <= 1'b0;
      freeze_q <= 1'b0;
      reg_busy_cnt_q <= 8'h00;
      O_PGM_START <= 1'b0;
      O_ERS_START <= 1'b0;
    end else begin
      O_PGM_START <= go_wel & (opcode_q == `OP_PROGRAM);
      O_ERS_START <= go_wel & (opcode_q == `OP_ERASE);
      if (reg_busy_cnt_q != 8'h00) begin
        reg_busy_cnt_q <= reg_busy_cnt_q - 8'h01;
      end
      // Only these two commands and OP_SOFT_RESET move the latch
      if (go && opcode_q == `OP_WRITE_ENABLE) begin
        write_enable_latch_q <= 1'b1;
      end else if (go && opcode_q == `OP_WRITE_DISABLE) begin
        write_enable_latch_q <= 1'b0;
      end
      if (go && opcode_q == `OP_SOFT_RESET) begin
        write_enable_latch_q <= 1'b0;
        freeze_q <= 1'b0;
        if (protection_volatility_q) begin
          block_protect_q <= `RST_BP_VOLATILE;
        end
      end
      if (wr_ok) begin
        reg_busy_cnt_q <= REG_WRITE_CYCLES[7:0];
        status_write_lock_q <= stat_byte_q[`PST_LOCK];
        if (!freeze_q) begin
          block_protect_q <= stat_byte_q[`PST_BP_HI:`PST_BP_LO];
        end
      end
      if (wr_cfg) begin
        latency_code_q <= cfg_byte_q[`CFG_LAT_HI:`CFG_LAT_LO];
        quad_io_q <= cfg_byte_q[`CFG_QUAD];
        // One-time bits only move away from zero here; soft reset clears freeze_q
        protection_volatility_q <= protection_volatility_q |
          cfg_byte_q[`CFG_VOLATILE_BP];
        freeze_q <= freeze_q | cfg_byte_q[`CFG_FREEZE];
        if (!freeze_q) begin
          protection_origin_q <= protection_origin_q |
            cfg_byte_q[`CFG_ORIGIN];
          parameter_placement_q <= parameter_placement_q |
            cfg_byte_q[`CFG_PARAM_TOP];
        end
      end
    end
  end

  // ==========================================================
  // Read-only flags follow the engine; busy also covers our register write time
  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      busy_flag_q <= 1'b0;
      prog_err_q <= 1'b0;
      erase_err_q <= 1'b0;
      erase_suspended_flag_q <= 1'b0;
      program_suspended_flag_q <= 1'b0;
    end else begin
      busy_flag_q <= busy_now;
      prog_err_q <= I_PROG_ERR;
      erase_err_q <= I_ERASE_ERR;
      erase_suspended_flag_q <= I_ERASE_SUSP;
      program_suspended_flag_q <= I_PROG_SUSP;
    end
  end

  // ==========================================================
  // Protection and configuration outputs to the array engine
  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_BLOCK_PROTECT <= 3'h0;
      O_PROT_BOTTOM <= 1'b0;
      O_PARAM_TOP <= 1'b0;
      O_QUAD_EN <= 1'b0;
      O_OTP_LOCK <= 1'b0;
    end else begin
      O_BLOCK_PROTECT <= block_protect_q;
      O_PROT_BOTTOM <= protection_origin_q;
      // Uniform parts have no small sectors to place
      O_PARAM_TOP <= parameter_placement_q & ~uniform_sectors_q;
      O_QUAD_EN <= quad_io_q;
      O_OTP_LOCK <= freeze_q;
    end
  end

  latency_lut u_latency_lut (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_code(latency_code_q),
    .o_fast_ddr(O_FAST_DDR_DUMMY),
    .o_quad_ddr(O_QUAD_DDR_DUMMY)
  );

  // ==========================================================
  // Interrupt events; set beats a same-cycle clear
  wire [`IRQ_WIDTH-1:0] irq_event = {busy_flag_q & ~busy_now,
    refused, wr_regs & wr_locked, I_ERASE_ERR & ~erase_err_q,
    I_PROG_ERR & ~prog_err_q};

  // ==========================================================
  // APB slave, no wait states; read data registered in the setup cycle
  wire apb_setup = I_PSEL & ~I_PENABLE;
  wire apb_wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
  reg [31:0] rdata_d;
  reg unmapped_d;

  always @* begin
    rdata_d = 32'h0000_0000;
    unmapped_d = 1'b0;
    if (I_PADDR == `OFS_PRIMARY_STATUS) begin
      rdata_d[7:0] = primary_status;
    end else if (I_PADDR == `OFS_CONFIGURATION_ONE) begin
      rdata_d[7:0] = configuration_one;
    end else if (I_PADDR == `OFS_SUSPEND_STATUS) begin
      rdata_d[7:0] = suspend_status;
    end else if (I_PADDR == `OFS_IRQ_STATUS) begin
      rdata_d[`IRQ_WIDTH-1:0] = irq_status_q;
    end else if (I_PADDR == `OFS_IRQ_MASK) begin
      rdata_d[`IRQ_WIDTH-1:0] = irq_mask_q;
    end else if (I_PADDR == `OFS_PART_CTRL) begin
      rdata_d[0] = uniform_sectors_q;
    end else begin
      unmapped_d = 1'b1;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_PRDATA <= 32'h0000_0000;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      irq_status_q <= {`IRQ_WIDTH{1'b0}};
      irq_mask_q <= `RST_IRQ_MASK;
      uniform_sectors_q <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      O_PREADY <= apb_setup;
      if (apb_setup) begin
        O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rdata_d;
        O_PSLVERR <= unmapped_d;
      end else begin
        O_PSLVERR <= 1'b0;
      end
      if (apb_wr && I_PADDR == `OFS_IRQ_STATUS) begin
        irq_status_q <= (irq_status_q &
          ~I_PWDATA[`IRQ_WIDTH-1:0]) | irq_event;
      end else begin
        irq_status_q <= irq_status_q | irq_event;
      end
      if (apb_wr && I_PADDR == `OFS_IRQ_MASK) begin
        irq_mask_q <= I_PWDATA[`IRQ_WIDTH-1:0];
      end
      if (apb_wr && I_PADDR == `OFS_PART_CTRL) begin
        uniform_sectors_q <= I_PWDATA[0];
      end
      O_IRQ <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule

// ---- bench/flash_regs_props.sv ----
// Concurrent checks on the ports of the flash status register bank.
// Assumes one clock domain and binding to the top design module.
`timescale 1ns/1ps
`include "flash_status_regs.vh"
module flash_regs_props (
  // Clock and reset
  input wire I_REF_CLK,
  input wire I_SRST,
  // APB
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] O_PRDATA,
  input wire O_PREADY,
  // Engine status
  input wire I_OP_BUSY,
  input wire I_PROG_ERR,
  input wire I_ERASE_ERR,
  input wire I_ERASE_SUSP,
  input wire I_PROG_SUSP,
  // Engine control
  input wire O_PGM_START,
  input wire O_ERS_START,
  input wire [2:0] O_BLOCK_PROTECT,
  input wire O_PROT_BOTTOM,
  input wire O_QUAD_EN,
  input wire O_OTP_LOCK,
  input wire [3:0] O_FAST_DDR_DUMMY,
  input wire [3:0] O_QUAD_DDR_DUMMY
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SRST);
  // ==========
  // History of inputs and outputs
  wire rd = O_PREADY && !I_PWRITE;
  wire rd_st = rd && I_PADDR == `OFS_PRIMARY_STATUS;
  wire rd_cf = rd && I_PADDR == `OFS_CONFIGURATION_ONE;
  wire rd_su = rd && I_PADDR == `OFS_SUSPEND_STATUS;
  wire [4:0] eng = {I_PROG_SUSP, I_ERASE_SUSP, I_ERASE_ERR, I_PROG_ERR,
    I_OP_BUSY};
  wire [5:0] cfo = {O_BLOCK_PROTECT, O_PROT_BOTTOM, O_QUAD_EN, O_OTP_LOCK};
  reg [4:0] e1, e2, e3;
  reg [5:0] c1, c2, c3;
  reg [2:0] v;
  // Windows older than reset are never trusted
  always @(posedge I_REF_CLK) begin
    v <= I_SRST ? 3'h0 : {v[1:0], 1'b1};
    e1 <= eng;
    e2 <= e1;
    e3 <= e2;
    c1 <= cfo;
    c2 <= c1;
    c3 <= c2;
  end
  wire e_eq = v[2] && e1 == e2 && e2 == e3;
  wire c_eq = v[2] && cfo == c1 && c1 == c2 && c2 == c3;
  // ==========
  // Properties
  property p_busy_seen;
    rd_st && v[2] && e2[0] && e3[0] |-> O_PRDATA[0];
  endproperty
  a_busy_seen: assert property (p_busy_seen) else $error("busy lost");
  property p_err_mirror;
    rd_st && e_eq |-> O_PRDATA[6:5] == {e1[1], e1[2]};
  endproperty
  a_err_mirror: assert property (p_err_mirror) else $error("err");
  property p_susp;
    rd_su && e_eq |-> O_PRDATA == {30'h0, e1[3], e1[4]};
  endproperty
  a_susp: assert property (p_susp) else $error("suspend");
  property p_cfg_out;
    rd_cf && c_eq |-> {O_PRDATA[31:8], O_PRDATA[5:4], O_PRDATA[1:0]} ==
      {24'h0, cfo[2], 1'b0, cfo[1:0]};
  endproperty
  a_cfg_out: assert property (p_cfg_out)
    else $error("cfg");
  property p_bp_out;
    rd_st && c_eq |-> O_PRDATA[4:2] == cfo[5:3];
  endproperty
  a_bp_out: assert property (p_bp_out) else $error("protect");
  property p_dummy;
    O_FAST_DDR_DUMMY == 4'h2 && O_QUAD_DDR_DUMMY == 4'h6 ||
    O_FAST_DDR_DUMMY == 4'h4 && O_QUAD_DDR_DUMMY == 4'h7 ||
    O_FAST_DDR_DUMMY == 4'h5 && O_QUAD_DDR_DUMMY == 4'h8 ||
    O_FAST_DDR_DUMMY == 4'h0 && O_QUAD_DDR_DUMMY == 4'h0;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy pair");
  property p_start_idle;
    O_PGM_START || O_ERS_START |-> !(v[2] && e1[0]);
  endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("busy");
  property p_start_pulse;
    O_PGM_START || O_ERS_START |=> !(O_PGM_START || O_ERS_START) [*3];
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("pulse");
endmodule

bind flash_status_config_regs flash_regs_props props_i (.*);

// ---- bench/link_host.sv ----
// Serial host model: opens frames and shifts bytes MSB first.
// Assumes mode 0; the link clock runs only inside a frame.
`timescale 1ns/1ps
module link_host (
  // Link pins
  output reg o_sck,
  output reg o_cs_n,
  output reg o_si,
  input wire i_so
);
  reg [7:0] rx;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    rx = 8'h00;
  end
  // ==========
  // Whole bytes only; rx keeps the last eight bits read
  task frame(input integer n, input [23:0] b);
    integer k;
    begin
      #5 o_cs_n = 1'b0;
      for (k = 0; k < n * 8; k = k + 1) begin
        o_si = b[23 - k];
        #100 o_sck = 1'b1;
        #90 rx = {rx[6:0], i_so};
        #10 o_sck = 1'b0;
      end
      #100 o_cs_n = 1'b1;
      // Released line shows the inverse, never a stale bit
      o_si = ~o_si;
      #300;
    end
  endtask
endmodule

// ---- bench/tb_top.sv ----
// Bench for the flash status bank: APB master, engine levels, link host.
// Assumes the host model and the bound checker compile alongside.
`timescale 1ns/1ps
`include "flash_status_regs.vh"
module tb_top;
  reg clk, srst, psel, pen, pwr, wp_n, err;
  reg [7:0] pa;
  reg [31:0] pwd, rd, r;
  reg [4:0] eng;
  wire [31:0] prd;
  wire rdy, slv, sck, cs_n, si, so, so_oe, pgm, ers, irq;
  wire bot, ptop, quad, frz;
  wire [2:0] bp;
  wire [3:0] fdum, qdum;
  integer error_cnt, checks, pgm_n, ers_n, i;
  flash_status_config_regs flash_status_config_regs_i (
    .I_REF_CLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd),
    .O_PREADY(rdy), .O_PSLVERR(slv), .I_SCK(sck), .I_CS_N(cs_n),
    .I_SI(si), .I_WP_N(wp_n), .O_SO(so), .O_SO_OE(so_oe),
    .I_OP_BUSY(eng[0]), .I_PROG_ERR(eng[1]), .I_ERASE_ERR(eng[2]),
    .I_ERASE_SUSP(eng[3]), .I_PROG_SUSP(eng[4]), .O_PGM_START(pgm),
    .O_ERS_START(ers), .O_BLOCK_PROTECT(bp), .O_PROT_BOTTOM(bot),
    .O_PARAM_TOP(ptop), .O_QUAD_EN(quad), .O_OTP_LOCK(frz),
    .O_FAST_DDR_DUMMY(fdum), .O_QUAD_DDR_DUMMY(qdum), .O_IRQ(irq));
  // Released SO shows the inverse, never a stale bit
  wire so_line = so_oe ? so : ~so;
  link_host link_host_i (.o_sck(sck), .o_cs_n(cs_n), .o_si(si),
    .i_so(so_line));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pgm === 1'b1) pgm_n = pgm_n + 1;
    if (ers === 1'b1) ers_n = ers_n + 1;
  end
  // ==========
  // Shared tasks
  function [31:0] st_of(input l, input [2:0] b, input w, input [4:0] e);
    st_of = {24'h0, l, e[1], e[2], b, w, e[0]};
  endfunction
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      @(posedge clk);
      while (rdy !== 1'b1 && n < 16) begin
        @(posedge clk);
        n = n + 1;
      end
      if (rdy !== 1'b1) begin
        error_cnt = error_cnt + 1;
        finish_test;
      end
      rd = prd;
      err = slv;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task idle;
    integer n;
    begin
      n = 0;
      apb(1'b0, `OFS_PRIMARY_STATUS, 32'h0);
      while (rd[0] !== 1'b0 && n < 40) begin
        apb(1'b0, `OFS_PRIMARY_STATUS, 32'h0);
        n = n + 1;
      end
      if (n == 40) begin
        error_cnt = error_cnt + 1;
        finish_test;
      end
    end
  endtask
  task settle;
    repeat (3) @(posedge clk);
  endtask
  // ==========
  // Main sequence
  initial begin
    srst = 1'b1;
    {psel, pen, pwr, err, pa, pwd, eng} = 0;
    wp_n = 1'b1;
    {error_cnt, checks, pgm_n, ers_n} = 0;
    r = $urandom(32'h5f0a62b6);
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    settle;
    rdc(`OFS_PRIMARY_STATUS, 32'h0);
    rdc(`OFS_CONFIGURATION_ONE, 32'h0);
    rdc(`OFS_SUSPEND_STATUS, 32'h0);
    rdc(`OFS_IRQ_MASK, 32'h0);
    rdc(8'h18, 32'h0);
    chk(err, 1);
    chk({fdum, qdum}, 8'h26);
    $display("test reset done");
    link_host_i.frame(3, 24'h011c00);
    idle;
    chk(rd, 32'h0);
    link_host_i.frame(1, 24'h060000);
    idle;
    chk(rd, st_of(0, 0, 1, 0));
    link_host_i.frame(3, 24'h019c82);
    rdc(`OFS_PRIMARY_STATUS, st_of(1, 7, 1, 1));
    idle;
    chk(rd, st_of(1, 7, 1, 0));
    rdc(`OFS_CONFIGURATION_ONE, 32'h82);
    chk({fdum, qdum, quad, bp}, 12'h58f);
    link_host_i.frame(2, 24'h050000);
    chk(link_host_i.rx, st_of(1, 7, 1, 0));
    chk(so_oe, 0);
    link_host_i.frame(2, 24'h350000);
    chk(link_host_i.rx, 32'h82);
    $display("test write done");
    apb(1'b1, `OFS_IRQ_STATUS, 32'h1f);
    wp_n <= 1'b0;
    link_host_i.frame(3, 24'h010000);
    idle;
    chk(rd, st_of(1, 7, 1, 0));
    rdc(`OFS_IRQ_STATUS, 32'h4);
    apb(1'b1, `OFS_IRQ_MASK, 32'h4);
    settle;
    chk(irq, 1);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h4);
    settle;
    chk(irq, 0);
    wp_n <= 1'b1;
    link_host_i.frame(3, 24'h010040);
    idle;
    chk(rd, st_of(0, 0, 1, 0));
    chk({fdum, qdum}, 8'h47);
    $display("test lock done");
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      @(posedge clk);
      eng <= (i == 0) ? 5'h1f : r[4:0];
      settle;
      apb(1'b1, `OFS_PRIMARY_STATUS, r);
      apb(1'b1, `OFS_SUSPEND_STATUS, ~r);
      rdc(`OFS_PRIMARY_STATUS, st_of(0, 0, 1, eng));
      rdc(`OFS_SUSPEND_STATUS, {30'h0, eng[3], eng[4]});
    end
    link_host_i.frame(2, 24'h070000);
    chk(link_host_i.rx, {30'h0, eng[3], eng[4]});
    @(posedge clk);
    eng <= 5'h0;
    $display("test flags done");
    link_host_i.frame(1, 24'h020000);
    link_host_i.frame(1, 24'hd80000);
    chk({pgm_n[3:0], ers_n[3:0]}, 8'h11);
    @(posedge clk);
    eng <= 5'h1;
    link_host_i.frame(1, 24'h020000);
    chk(pgm_n, 1);
    @(posedge clk);
    eng <= 5'h0;
    link_host_i.frame(1, 24'h040000);
    idle;
    chk(rd, st_of(0, 0, 0, 0));
    link_host_i.frame(1, 24'h020000);
    chk(pgm_n, 1);
    $display("test start done");
    link_host_i.frame(1, 24'h060000);
    link_host_i.frame(3, 24'h011c3d);
    idle;
    rdc(`OFS_CONFIGURATION_ONE, 32'h2d);
    chk({bot, frz, ptop}, 3'h7);
    apb(1'b1, `OFS_PART_CTRL, 32'h1);
    settle;
    chk(ptop, 0);
    link_host_i.frame(3, 24'h010000);
    idle;
    chk(rd, st_of(0, 7, 1, 0));
    rdc(`OFS_CONFIGURATION_ONE, 32'h2d);
    link_host_i.frame(1, 24'hf00000);
    idle;
    chk(rd, st_of(0, 7, 0, 0));
    link_host_i.frame(1, 24'h060000);
    link_host_i.frame(3, 24'h0100c0);
    idle;
    chk(rd, st_of(0, 0, 1, 0));
    rdc(`OFS_CONFIGURATION_ONE, 32'hec);
    chk({fdum, qdum}, 8'h00);
    $display("test otp done");
    finish_test;
  end
endmodule
